// ==== design/exec_pkg.sv ====
// shared constants and carrier types for the branch and bit-clear execution block
package exec_pkg;

    localparam int PC_WIDTH = 21;
    localparam int ADDR_WIDTH = 12;

    // instruction cycle phases
    typedef enum logic [1:0]
    {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } phase_type;

    // decoded operation kinds
    typedef enum logic [2:0]
    {
        OP_NONE = 3'b000,
        OP_AND_ACCUM_WITH_FILE = 3'b001,
        OP_CLEAR_FILE_BIT = 3'b010,
        OP_BRANCH_ON_CARRY = 3'b011,
        OP_BRANCH_ON_NEGATIVE = 3'b100
    } op_type;

    // opcode patterns and field positions
    localparam logic [5:0] OPC_AND_ACCUM_WITH_FILE = 6'h05;
    localparam logic [3:0] OPC_CLEAR_FILE_BIT = 4'h9;
    localparam logic [7:0] OPC_BRANCH_ON_CARRY = 8'he2;
    localparam logic [7:0] OPC_BRANCH_ON_NEGATIVE = 8'h6e;
    localparam int POS_DEST = 9;
    localparam int POS_ACCESS = 8;
    localparam int POS_BIT_LO = 9;

    // file addressing
    localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;

    // values after reset
    localparam logic [15:0] RESET_INSTR = 16'h0000;
    localparam logic [7:0] RESET_DATA = 8'h00;
    localparam logic [ADDR_WIDTH-1:0] RESET_ADDR = 12'h000;
    localparam logic [PC_WIDTH-1:0] RESET_PC = 21'h000000;

    typedef struct packed
    {
        logic [ADDR_WIDTH-1:0] addr;
        logic rd;
        logic we;
        logic [7:0] wdata;
    } file_port_type;

    typedef struct packed
    {
        logic we;
        logic [7:0] data;
    } accum_port_type;

    typedef struct packed
    {
        logic we;
        logic negative;
        logic zero;
    } flag_port_type;

    typedef struct packed
    {
        logic load;
        logic [PC_WIDTH-1:0] target;
    } pc_port_type;

endpackage : exec_pkg

// ==== design/file_addr_gen.sv ====
// file address generation for access bank, banked and indexed literal offset modes
`timescale 1ns/100ps
`default_nettype none

module file_addr_gen
(
    input wire logic [7:0] file_i,
    input wire logic access_sel_i,
    input wire logic [3:0] bank_pointer_i,
    input wire logic ext_set_en_i,
    input wire logic [exec_pkg::ADDR_WIDTH-1:0] index_base_i,
    output logic [exec_pkg::ADDR_WIDTH-1:0] addr_o
);

    always_comb
    begin
        if (access_sel_i)
        begin
            addr_o = {bank_pointer_i, file_i};
        end
        else if (ext_set_en_i && (file_i <= exec_pkg::INDEXED_LIMIT))
        begin
            addr_o = index_base_i + {4'h0, file_i};
        end
        else if (file_i < exec_pkg::ACCESS_SPLIT)
        begin
            addr_o = {exec_pkg::ACCESS_LOW_BANK, file_i};
        end
        else
        begin
            // access bank upper part, from 0x60, maps to special registers
            addr_o = {exec_pkg::ACCESS_HIGH_BANK, file_i};
        end
    end

endmodule : file_addr_gen

`default_nettype wire

// ==== design/and_bitclear_branch_exec.sv ====
// execution of and-with-file, bit clear and two conditional branches
`timescale 1ns/100ps
`default_nettype none

// Contract
// - and accumulator with file, set n z
// - dest bit 0 accumulator, 1 file
// - access bit 0 access bank, 1 banked
// - extended set low addresses use indexed offset
// - branch on carry, signed offset, no flags
// - branch on negative, printed opcode, no flags
// - taken target is incremented pc plus 2n
// - taken two cycles, untaken one, no write
// - clear chosen bit, read early, write late
module and_bitclear_branch_exec
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [15:0] instr_i,
    input wire logic [7:0] accum_i,
    input wire logic [7:0] file_rdata_i,
    input wire logic carry_i,
    input wire logic negative_i,
    input wire logic [3:0] bank_pointer_i,
    input wire logic ext_set_en_i,
    input wire logic [exec_pkg::ADDR_WIDTH-1:0] index_base_i,
    input wire logic [exec_pkg::PC_WIDTH-1:0] pc_i,
    output exec_pkg::phase_type phase_o,
    output exec_pkg::file_port_type file_o,
    output exec_pkg::accum_port_type accum_o,
    output exec_pkg::flag_port_type flag_o,
    output exec_pkg::pc_port_type pc_o,
    output logic nop_cycle_o
);

    exec_pkg::phase_type phase_r;
    exec_pkg::phase_type phase_nxt;
    exec_pkg::op_type op_r;
    exec_pkg::op_type op_nxt;
    logic [15:0] instr_r;
    logic [7:0] operand_r;
    logic nop_cycle_r;
    logic taken_r;
    logic [exec_pkg::ADDR_WIDTH-1:0] addr_nxt;
    exec_pkg::file_port_type file_r;
    exec_pkg::accum_port_type accum_r;
    exec_pkg::flag_port_type flag_r;
    exec_pkg::pc_port_type pc_r;
    logic [7:0] and_result;
    logic [7:0] clear_result;
    logic [7:0] bit_mask;
    logic branch_taken;
    logic [exec_pkg::PC_WIDTH-1:0] pc_offset;

    file_addr_gen u_addr
    (
        .file_i(instr_i[7:0]),
        .access_sel_i(instr_i[exec_pkg::POS_ACCESS]),
        .bank_pointer_i(bank_pointer_i),
        .ext_set_en_i(ext_set_en_i),
        .index_base_i(index_base_i),
        .addr_o(addr_nxt)
    );

    always_comb
    begin
        case (phase_r)
            exec_pkg::PH_Q1: phase_nxt = exec_pkg::PH_Q2;
            exec_pkg::PH_Q2: phase_nxt = exec_pkg::PH_Q3;
            exec_pkg::PH_Q3: phase_nxt = exec_pkg::PH_Q4;
            exec_pkg::PH_Q4: phase_nxt = exec_pkg::PH_Q1;
            default: phase_nxt = exec_pkg::PH_Q1;
        endcase
    end

    always_comb
    begin
        if (instr_i[15:10] == exec_pkg::OPC_AND_ACCUM_WITH_FILE)
        begin
            op_nxt = exec_pkg::OP_AND_ACCUM_WITH_FILE;
        end
        else if (instr_i[15:12] == exec_pkg::OPC_CLEAR_FILE_BIT)
        begin
            op_nxt = exec_pkg::OP_CLEAR_FILE_BIT;
        end
        else if (instr_i[15:8] == exec_pkg::OPC_BRANCH_ON_CARRY)
        begin
            op_nxt = exec_pkg::OP_BRANCH_ON_CARRY;
        end
        else if (instr_i[15:8] == exec_pkg::OPC_BRANCH_ON_NEGATIVE)
        begin
            op_nxt = exec_pkg::OP_BRANCH_ON_NEGATIVE;
        end
        else
        begin
            op_nxt = exec_pkg::OP_NONE;
        end
    end

    // bitwise and of accumulator and operand
    assign and_result = accum_i & operand_r;
    assign bit_mask = 8'h01 << instr_r[exec_pkg::POS_BIT_LO +: 3];
    // only the chosen bit is cleared
    assign clear_result = operand_r & ~bit_mask;
    assign pc_offset = {{(exec_pkg::PC_WIDTH - 9){instr_r[7]}}, instr_r[7:0], 1'b0};

    always_comb
    begin
        case (op_r)
            exec_pkg::OP_BRANCH_ON_CARRY: branch_taken = carry_i;
            exec_pkg::OP_BRANCH_ON_NEGATIVE: branch_taken = negative_i;
            default: branch_taken = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            phase_r <= exec_pkg::PH_Q1;
        end
        else
        begin
            phase_r <= phase_nxt;
        end
    end

    // decode in the first phase; nothing is decoded in a flushed cycle
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            instr_r <= exec_pkg::RESET_INSTR;
            op_r <= exec_pkg::OP_NONE;
        end
        else if (phase_r == exec_pkg::PH_Q1)
        begin
            instr_r <= instr_i;
            op_r <= nop_cycle_r ? exec_pkg::OP_NONE : op_nxt;
        end
    end

    // file read in second phase, operand captured at its end
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            file_r <= '0;
            operand_r <= exec_pkg::RESET_DATA;
        end
        else
        begin
            case (phase_r)
                exec_pkg::PH_Q1:
                begin
                    file_r.addr <= addr_nxt;
                    file_r.rd <= !nop_cycle_r && ((op_nxt == exec_pkg::OP_AND_ACCUM_WITH_FILE)
                        || (op_nxt == exec_pkg::OP_CLEAR_FILE_BIT));
                end
                exec_pkg::PH_Q2:
                begin
                    file_r.rd <= 1'b0;
                    operand_r <= file_rdata_i;
                end
                exec_pkg::PH_Q3:
                begin
                    // and result written back to file when dest bit is 1; bit clear always writes the file
                    if (op_r == exec_pkg::OP_AND_ACCUM_WITH_FILE && instr_r[exec_pkg::POS_DEST])
                    begin
                        file_r.we <= 1'b1;
                        file_r.wdata <= and_result;
                    end
                    else if (op_r == exec_pkg::OP_CLEAR_FILE_BIT)
                    begin
                        file_r.we <= 1'b1;
                        file_r.wdata <= clear_result;
                    end
                end
                exec_pkg::PH_Q4:
                begin
                    file_r.we <= 1'b0;
                end
                default:
                begin
                    file_r.rd <= 1'b0;
                end
            endcase
        end
    end

    // accumulator and flag write in fourth phase
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            accum_r <= '0;
            flag_r <= '0;
        end
        else if (phase_r == exec_pkg::PH_Q3 && op_r == exec_pkg::OP_AND_ACCUM_WITH_FILE)
        begin
            // accumulator gets result when dest bit is 0
            accum_r.we <= !instr_r[exec_pkg::POS_DEST];
            accum_r.data <= and_result;
            // only negative and zero flags change
            flag_r.we <= 1'b1;
            flag_r.negative <= and_result[7];
            flag_r.zero <= (and_result == 8'h00);
        end
        else if (phase_r == exec_pkg::PH_Q4)
        begin
            accum_r.we <= 1'b0;
            flag_r.we <= 1'b0;
        end
    end

    // program counter load in fourth phase of a taken branch
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pc_r <= '0;
            taken_r <= 1'b0;
        end
        else if (phase_r == exec_pkg::PH_Q3)
        begin
            // incremented pc plus twice the offset
            pc_r.target <= pc_i + pc_offset;
            // untaken branch leaves pc to its own increment
            pc_r.load <= branch_taken;
            taken_r <= branch_taken;
        end
        else if (phase_r == exec_pkg::PH_Q4)
        begin
            pc_r.load <= 1'b0;
            taken_r <= 1'b0;
        end
    end

    // taken branch flushes the whole following cycle
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            nop_cycle_r <= 1'b0;
        end
        else if (phase_r == exec_pkg::PH_Q4)
        begin
            nop_cycle_r <= taken_r;
        end
    end

    assign phase_o = phase_r;
    assign file_o = file_r;
    assign accum_o = accum_r;
    assign flag_o = flag_r;
    assign pc_o = pc_r;
    assign nop_cycle_o = nop_cycle_r;

endmodule : and_bitclear_branch_exec

`default_nettype wire

// ==== test/exec_checker.sv ====
// assertion checker for the and, bit clear and branch execution block
`timescale 1ns/100ps
`default_nettype none
module exec_checker
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [15:0] instr_i,
    input wire logic [7:0] accum_i,
    input wire logic [7:0] file_rdata_i,
    input wire logic carry_i,
    input wire logic negative_i,
    input wire logic [exec_pkg::PC_WIDTH-1:0] pc_i,
    input wire exec_pkg::phase_type phase_o,
    input wire exec_pkg::file_port_type file_o,
    input wire exec_pkg::accum_port_type accum_o,
    input wire exec_pkg::flag_port_type flag_o,
    input wire exec_pkg::pc_port_type pc_o,
    input wire logic nop_cycle_o
);
    // word taken at the q1 edge, still held in q4
    logic [15:0] ir_r;
    logic [7:0] res;
    logic q4;
    assign res = accum_o.we ? accum_o.data : file_o.wdata;
    assign q4 = phase_o == exec_pkg::PH_Q4 && !nop_cycle_o;
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            ir_r <= 16'h0000;
        else if (phase_o == exec_pkg::PH_Q1)
            ir_r <= instr_i;
    end
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    sequence write_s;
        ##2 (file_o.we || accum_o.we) && phase_o == exec_pkg::PH_Q4;
    endsequence
    sequence nop_s;
        (nop_cycle_o && !file_o.rd && !pc_o.load) [*4] ##1 !nop_cycle_o;
    endsequence
    rd_then_write_a:
        assert property (file_o.rd |-> write_s) else $error("read without write");
    and_result_a:
        assert property (accum_o.we |-> !file_o.we
            && accum_o.data == ($past(accum_i) & $past(file_rdata_i, 2)))
        else $error("and result wrong");
    flag_value_a:
        assert property (flag_o.we |-> flag_o.negative == res[7] && flag_o.zero == (res == 8'h00))
        else $error("flags wrong");
    clear_bit_a:
        assert property (file_o.we && !flag_o.we
            |-> file_o.wdata == ($past(file_rdata_i, 2) & ~(8'h01 << ir_r[11:9])))
        else $error("bit clear wrong");
    carry_take_a:
        assert property (q4 && ir_r[15:8] == exec_pkg::OPC_BRANCH_ON_CARRY
            |-> pc_o.load == $past(carry_i) && !flag_o.we) else $error("carry branch wrong");
    neg_take_a:
        assert property (q4 && ir_r[15:8] == exec_pkg::OPC_BRANCH_ON_NEGATIVE
            |-> pc_o.load == $past(negative_i) && !flag_o.we) else $error("neg branch wrong");
    pc_target_a:
        assert property (pc_o.load |-> pc_o.target == $past(pc_i) + {{12{ir_r[7]}}, ir_r[7:0], 1'b0})
        else $error("target wrong");
    nop_after_a:
        assert property (pc_o.load |=> nop_s) else $error("nop cycle wrong");
    rd_strobe_a:
        assert property (phase_o == exec_pkg::PH_Q2 && !nop_cycle_o
            && (ir_r[15:10] == exec_pkg::OPC_AND_ACCUM_WITH_FILE
            || ir_r[15:12] == exec_pkg::OPC_CLEAR_FILE_BIT) |-> file_o.rd)
        else $error("read strobe missing");
endmodule : exec_checker
bind and_bitclear_branch_exec exec_checker i_checker
(
    .clk_i(clk_i), .reset_n_i(reset_n_i), .instr_i(instr_i), .accum_i(accum_i),
    .file_rdata_i(file_rdata_i), .carry_i(carry_i), .negative_i(negative_i), .pc_i(pc_i),
    .phase_o(phase_o), .file_o(file_o), .accum_o(accum_o), .flag_o(flag_o), .pc_o(pc_o),
    .nop_cycle_o(nop_cycle_o)
);
`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for the execution block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [15:0] instr_i = 16'h0000;
    logic [7:0] accum_i = 8'h00;
    logic [7:0] file_rdata_i = 8'h00;
    logic carry_i = 1'b0;
    logic negative_i = 1'b0;
    logic [3:0] bank_pointer_i = 4'h3;
    logic ext_set_en_i = 1'b0;
    logic [11:0] index_base_i = 12'h200;
    logic [20:0] pc_i = 21'h000000;
    exec_pkg::phase_type phase_o;
    exec_pkg::file_port_type file_o;
    exec_pkg::accum_port_type accum_o;
    exec_pkg::flag_port_type flag_o;
    exec_pkg::pc_port_type pc_o;
    logic nop_cycle_o;
    int errors = 0;
    int n_checks = 0;
    and_bitclear_branch_exec i_dut
    (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .instr_i(instr_i), .accum_i(accum_i),
        .file_rdata_i(file_rdata_i), .carry_i(carry_i), .negative_i(negative_i),
        .bank_pointer_i(bank_pointer_i), .ext_set_en_i(ext_set_en_i),
        .index_base_i(index_base_i), .pc_i(pc_i), .phase_o(phase_o), .file_o(file_o),
        .accum_o(accum_o), .flag_o(flag_o), .pc_o(pc_o), .nop_cycle_o(nop_cycle_o)
    );
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report
    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // present a word in q1, return in its q4
    task automatic exec(input logic [15:0] ins);
        for (int i = 0; i < 8 && phase_o !== exec_pkg::PH_Q1; i++)
            @(negedge clk_i);
        if (phase_o !== exec_pkg::PH_Q1)
        begin
            errors++;
            final_report();
        end
        else
        begin
            instr_i = ins;
            repeat (3) @(negedge clk_i);
        end
    endtask : exec
    task automatic and_case(input logic [15:0] ins, input logic [7:0] acc, input logic [7:0] rd,
        input logic [11:0] adr);
        logic [7:0] res;
        res = acc & rd;
        accum_i = acc;
        file_rdata_i = rd;
        exec(ins);
        chk({accum_o.we, file_o.we}, {~ins[9], ins[9]});
        chk(ins[9] ? file_o.wdata : accum_o.data, res);
        chk(flag_o, {1'b1, res[7], res == 8'h00});
        chk(file_o.addr, adr);
    endtask : and_case
    task automatic t_and;
        and_case(16'h1480, 8'h17, 8'hc2, 12'hf80);
        and_case(16'h1720, 8'hf0, 8'h9c, 12'h320);
        and_case(16'h1630, 8'h0f, 8'hf0, 12'h030);
    endtask : t_and
    task automatic clr_case(input logic [15:0] ins, input logic [7:0] rd, input logic [11:0] adr);
        file_rdata_i = rd;
        exec(ins);
        chk({file_o.we, flag_o.we, accum_o.we}, 3'b100);
        chk(file_o.wdata, rd & ~(8'h01 << ins[11:9]));
        chk(file_o.addr, adr);
    endtask : clr_case
    task automatic t_clear;
        ext_set_en_i = 1'b1;
        clr_case(16'h9e10, 8'hc7, 12'h210);
        clr_case(16'h9c5f, 8'hff, 12'h25f);
        clr_case(16'h9060, 8'h81, 12'hf60);
        clr_case(16'h9344, 8'h0f, 12'h344);
    endtask : t_clear
    task automatic br_case(input logic [15:0] ins, input logic c, input logic n,
        input logic [20:0] pc, input logic tk);
        carry_i = c;
        negative_i = n;
        pc_i = pc;
        exec(ins);
        chk({pc_o.load, flag_o.we, file_o.we, accum_o.we}, {tk, 3'b000});
        if (tk)
            chk(pc_o.target, pc + {{12{ins[7]}}, ins[7:0], 1'b0});
        @(negedge clk_i);
        chk(nop_cycle_o, tk);
    endtask : br_case
    task automatic t_branch;
        br_case(16'he205, 1'b1, 1'b0, 21'h000102, 1'b1);
        // word during the nop cycle must be dropped
        exec(16'h1720);
        chk({accum_o.we, file_o.we, flag_o.we, nop_cycle_o}, 4'h1);
        br_case(16'he27f, 1'b0, 1'b1, 21'h000200, 1'b0);
        br_case(16'h6e10, 1'b1, 1'b0, 21'h000300, 1'b0);
        // neighbouring branch code with carry set is not decoded here
        exec(16'he305);
        chk({pc_o.load, flag_o.we, file_o.we, accum_o.we}, 4'h0);
        br_case(16'h6e80, 1'b0, 1'b1, 21'h001000, 1'b1);
        // bit clear inside the flushed cycle must not write
        exec(16'h9344);
        chk({file_o.we, pc_o.load, nop_cycle_o}, 3'b001);
        br_case(16'he27f, 1'b1, 1'b0, 21'h000200, 1'b1);
    endtask : t_branch
    initial
    begin
        forever #25 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (12) @(negedge clk_i);
        reset_n_i = 1'b1;
        t_and();
        t_clear();
        t_branch();
        final_report();
    end
endmodule : testbench
`default_nettype wire
